/* File: verilog/gxr_encoder.v */
// Guest exit reason encoder: writes exit code and detail words on an exit.
// Notes on behaviour
// - Every exit that wins priority writes a reason code, except an intercept above 8Dh, which is refused.
// - An intercept exit code equals its intercept vector bit index.
// - A protected port access reports 7Bh with details in word one.
// - A protected model register access reports 7Ch.
// - A legacy floating-point freeze awaiting interrupt reports 7Eh.
// - Monitor-wait reports 8Ch when armed, otherwise 8Bh.
// - A nested page fault reports 400h with error code in word one.
// - A nested page fault puts the faulting guest address in word two.
// - An incomplete virtual interprocessor interrupt reports 401h.
// - An unaccelerated virtual controller access reports 402h.
// - Invalid guest state at a guest run reports all ones.
`timescale 1ns/1ps
`include "gxr_consts.vh"
module gxr_encoder #(
    parameter IVW = 8
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Exit causes, one-cycle pulses from core logic
    input wire invalid_guest_state_exit,
    input wire nested_page_fault_exit,
    input wire virtual_ipi_incomplete_exit,
    input wire unaccelerated_vapic_exit,
    input wire port_io_exit,
    input wire model_reg_access_exit,
    input wire fp_error_freeze_exit,
    input wire shutdown_exit,
    input wire monitor_wait_exit,
    input wire intercept_exit,
    // Cause qualifiers
    input wire monitor_armed,
    input wire fp_legacy_enable,
    input wire [IVW-1:0] intercept_bit,
    // Detail words supplied with the cause
    input wire [`GXR_DET_W-1:0] detail_one_in,
    input wire [`GXR_DET_W-1:0] detail_two_in,
    // Guest control block write
    output reg exit_valid,
    output reg [`GXR_CODE_W-1:0] exit_code,
    output reg [`GXR_DET_W-1:0] exit_detail_one,
    output reg [`GXR_DET_W-1:0] exit_detail_two,
    output reg exit_reject
);
    wire [`GXR_NCAUSE-1:0] raw;
    wire [`GXR_NCAUSE-1:0] req;
    wire [`GXR_SEL_W-1:0] sel;
    wire any;
    wire [`GXR_CODE_W-1:0] ivec_code;
    wire ivec_ok;
    reg next_valid;
    reg next_reject;
    reg [`GXR_CODE_W-1:0] next_code;
    reg [`GXR_DET_W-1:0] next_d1;
    reg [`GXR_DET_W-1:0] next_d2;
    genvar g;

    // Cause pulses in priority order, before any qualifier is applied.
    assign raw[`GXR_C_INVALID] = invalid_guest_state_exit;
    assign raw[`GXR_C_NPF] = nested_page_fault_exit;
    assign raw[`GXR_C_VIPI] = virtual_ipi_incomplete_exit;
    assign raw[`GXR_C_NOACCEL] = unaccelerated_vapic_exit;
    assign raw[`GXR_C_PORT_IO] = port_io_exit;
    assign raw[`GXR_C_MODEL_REG] = model_reg_access_exit;
    assign raw[`GXR_C_FP_FREEZE] = fp_error_freeze_exit;
    assign raw[`GXR_C_SHUTDOWN] = shutdown_exit;
    assign raw[`GXR_C_MONITOR_WAIT_INSTR] = monitor_wait_exit;
    assign raw[`GXR_C_INTERCEPT] = intercept_exit;

    // Only the freeze cause is gated by a qualifier: a freeze while legacy
    // floating-point handling is off is not an exit at all.
    generate
        for (g = 0; g < `GXR_NCAUSE; g = g + 1)
        begin : g_cause
            if (g == `GXR_C_FP_FREEZE)
            begin : g_gated
                assign req[g] = raw[g] & fp_legacy_enable;
            end
            else
            begin : g_plain
                assign req[g] = raw[g];
            end
        end
    endgenerate

    // Invalid state wins since no guest ran; lower index is higher priority.
    // Only one record can be written per cycle, so simultaneous causes are
    // resolved here and the losers are dropped rather than queued.
    gxr_prio #(
        .N(`GXR_NCAUSE),
        .IW(`GXR_SEL_W)
    ) u_prio (
        .req(req),
        .idx(sel),
        .any(any)
    );

    // The intercept code is the vector bit index itself, widened with zeros.
    assign ivec_code = {{(`GXR_CODE_W-IVW){1'h0}}, intercept_bit};
    assign ivec_ok = (ivec_code <= `GXR_MAX_INTERCEPT);

    always @*
    begin
        next_valid = 1'h0;
        next_reject = 1'h0;
        next_code = exit_code;
        // Causes without details write zeros, so no stale word is left.
        next_d1 = `GXR_ZERO_DET;
        next_d2 = `GXR_ZERO_DET;
        if (any)
        begin
            next_valid = 1'h1;
            case (sel)
            `GXR_C_INVALID:
            begin
                next_code = `GXR_CODE_INVALID;
            end
            `GXR_C_NPF:
            begin
                next_code = `GXR_CODE_NPF;
                next_d1 = detail_one_in;
                next_d2 = detail_two_in;
            end
            `GXR_C_VIPI:
            begin
                next_code = `GXR_CODE_VIPI;
                next_d1 = detail_one_in;
                next_d2 = detail_two_in;
            end
            `GXR_C_NOACCEL:
            begin
                next_code = `GXR_CODE_NOACCEL;
                next_d1 = detail_one_in;
                next_d2 = detail_two_in;
            end
            `GXR_C_PORT_IO:
            begin
                next_code = `GXR_CODE_PORT_IO;
                next_d1 = detail_one_in;
            end
            `GXR_C_MODEL_REG:
            begin
                next_code = `GXR_CODE_MODEL_REG;
            end
            `GXR_C_FP_FREEZE:
            begin
                next_code = `GXR_CODE_FP_FREEZE;
            end
            `GXR_C_SHUTDOWN:
            begin
                // Shutdown carries no detail words; both go out as zero.
                next_code = `GXR_CODE_SHUTDOWN;
            end
            `GXR_C_MONITOR_WAIT_INSTR:
            begin
                if (monitor_armed)
                    next_code = `GXR_CODE_MONITOR_WAIT_INSTR_ARMED;
                else
                    next_code = `GXR_CODE_MONITOR_WAIT_INSTR;
            end
            `GXR_C_INTERCEPT:
            begin
                // An out-of-range index would name an unassigned code.
                if (ivec_ok)
                    next_code = ivec_code;
                else
                begin
                    next_valid = 1'h0;
                    next_reject = 1'h1;
                end
            end
            default:
            begin
                next_valid = 1'h0;
                next_reject = 1'h1;
            end
            endcase
        end
    end

    // Record strobes are single-cycle pulses, rebuilt every clock.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            exit_valid <= 1'h0;
            exit_reject <= 1'h0;
        end
        else
        begin
            exit_valid <= next_valid;
            exit_reject <= next_reject;
        end
    end

    // The code stands until the next record; a refused intercept leaves the
    // previous code in place so the host never sees an unassigned value.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            exit_code <= `GXR_ZERO_CODE;
        end
        else if (next_valid)
        begin
            exit_code <= next_code;
        end
    end

    // Detail words load only with a record, so a host still reading the
    // previous record is not disturbed by cycles without an exit.
    always @(posedge clk or negedge rstn)
    begin
        if (!rstn)
        begin
            exit_detail_one <= `GXR_ZERO_DET;
            exit_detail_two <= `GXR_ZERO_DET;
        end
        else if (next_valid)
        begin
            exit_detail_one <= next_d1;
            exit_detail_two <= next_d2;
        end
    end
endmodule

/* File: shared/gxr_consts.vh */
// Exit codes, detail widths and cause indices for the guest exit encoder.
`ifndef GXR_CONSTS_VH
`define GXR_CONSTS_VH
`define GXR_CODE_W 64
`define GXR_DET_W 64
`define GXR_MAX_INTERCEPT 64'h000000000000008d
`define GXR_CODE_PORT_IO 64'h000000000000007b
`define GXR_CODE_MODEL_REG 64'h000000000000007c
`define GXR_CODE_FP_FREEZE 64'h000000000000007e
`define GXR_CODE_SHUTDOWN 64'h000000000000007f
`define GXR_CODE_MONITOR_WAIT_INSTR 64'h000000000000008b
`define GXR_CODE_MONITOR_WAIT_INSTR_ARMED 64'h000000000000008c
`define GXR_CODE_NPF 64'h0000000000000400
`define GXR_CODE_VIPI 64'h0000000000000401
`define GXR_CODE_NOACCEL 64'h0000000000000402
`define GXR_CODE_INVALID 64'hffffffffffffffff
`define GXR_ZERO_DET 64'h0000000000000000
`define GXR_ZERO_CODE 64'h0000000000000000
`define GXR_SEL_W 4
`define GXR_NCAUSE 10
`define GXR_C_INVALID 0
`define GXR_C_NPF 1
`define GXR_C_VIPI 2
`define GXR_C_NOACCEL 3
`define GXR_C_PORT_IO 4
`define GXR_C_MODEL_REG 5
`define GXR_C_FP_FREEZE 6
`define GXR_C_SHUTDOWN 7
`define GXR_C_MONITOR_WAIT_INSTR 8
`define GXR_C_INTERCEPT 9
`endif

/* File: verilog/gxr_prio.v */
// Fixed-priority picker returning the index of the lowest set request bit.
`timescale 1ns/1ps
module gxr_prio #(
    parameter N = 10,
    parameter IW = 4
) (
    // Requests
    input wire [N-1:0] req,
    // Result
    output reg [IW-1:0] idx,
    output reg any
);
    integer i;
    always @*
    begin
        idx = {IW{1'h0}};
        any = 1'h0;
        for (i = N - 1; i >= 0; i = i - 1)
        begin
            if (req[i])
            begin
                idx = i[IW-1:0];
                any = 1'h1;
            end
        end
    end
endmodule

/* File: test/gxr_host.sv */
// Host side model that keeps the last exit code it has read.
`timescale 1ns/1ps
module gxr_host (
    // Clock
    input wire clk,
    // Exit record from the encoder
    input wire exit_valid,
    input wire [63:0] exit_code,
    // Last code taken by the host
    output reg [63:0] seen_code
);
    initial seen_code = 64'h0;
    always @(posedge clk)
        if (exit_valid)
            seen_code <= exit_code;
endmodule

/* File: test/gxr_encoder_props.sv */
// Port assertions for the exit encoder.
`timescale 1ns/1ps
`include "gxr_consts.vh"
module gxr_encoder_props #(
    parameter IVW = 8
) (
    // Clock and reset
    input wire clk,
    input wire rstn,
    // Exit causes
    input wire invalid_guest_state_exit,
    input wire nested_page_fault_exit,
    input wire virtual_ipi_incomplete_exit,
    input wire unaccelerated_vapic_exit,
    input wire port_io_exit,
    input wire model_reg_access_exit,
    input wire fp_error_freeze_exit,
    input wire shutdown_exit,
    input wire monitor_wait_exit,
    input wire intercept_exit,
    // Cause qualifiers
    input wire monitor_armed,
    input wire fp_legacy_enable,
    input wire [IVW-1:0] intercept_bit,
    // Detail words in
    input wire [63:0] detail_one_in,
    input wire [63:0] detail_two_in,
    // Exit record
    input wire exit_valid,
    input wire exit_reject,
    input wire [63:0] exit_code,
    input wire [63:0] exit_detail_one,
    input wire [63:0] exit_detail_two
);
    wire [9:0] c = {intercept_exit, monitor_wait_exit, shutdown_exit,
        fp_error_freeze_exit, model_reg_access_exit, port_io_exit,
        unaccelerated_vapic_exit, virtual_ipi_incomplete_exit,
        nested_page_fault_exit, invalid_guest_state_exit};
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    a_invalid_all_ones: assert property (c[0] |=>
        exit_valid && exit_code == `GXR_CODE_INVALID) else $error("invalid");
    a_npf_record: assert property (c == 10'h002 |=>
        exit_code == `GXR_CODE_NPF && exit_detail_one == $past(detail_one_in)
        && exit_detail_two == $past(detail_two_in)) else $error("npf");
    a_vapic_code: assert property (
        c == 10'h004 || c == 10'h008 |=>
        exit_code == ($past(c[2]) ? `GXR_CODE_VIPI : `GXR_CODE_NOACCEL)
        && exit_detail_one == $past(detail_one_in)
        && exit_detail_two == $past(detail_two_in)) else $error("vapic");
    a_port_code: assert property (c == 10'h010 |=>
        exit_code == `GXR_CODE_PORT_IO &&
        exit_detail_one == $past(detail_one_in)) else $error("port");
    a_model_code: assert property (c == 10'h020 |=>
        exit_code == `GXR_CODE_MODEL_REG) else $error("model reg");
    a_fp_freeze: assert property (
        c == 10'h040 && fp_legacy_enable |=>
        exit_code == `GXR_CODE_FP_FREEZE) else $error("fp freeze");
    a_monitor_wait_instr_code: assert property (c == 10'h100 |=> exit_code ==
        ($past(monitor_armed) ? `GXR_CODE_MONITOR_WAIT_INSTR_ARMED : `GXR_CODE_MONITOR_WAIT_INSTR))
        else $error("monitor_wait_instr");
    a_icpt_index: assert property (c[9:0] == 10'h200 &&
        intercept_bit <= 8'h8d |=> exit_valid && exit_code == $past(
        intercept_bit)) else $error("intercept");
    a_icpt_refuse: assert property (c == 10'h200 &&
        intercept_bit > 8'h8d |=> exit_reject && !exit_valid &&
        $stable(exit_code)) else $error("refuse");
    a_exit_record: assert property (c != 10'h0 && c != 10'h040 |=>
        exit_valid || exit_reject) else $error("no record");
    c_npf: cover property (exit_valid && exit_code == `GXR_CODE_NPF);
    c_refuse: cover property (exit_reject);
    c_both: cover property (c == 10'h003);
endmodule
bind gxr_encoder gxr_encoder_props #(.IVW(IVW)) u_props (
    .clk(clk),
    .rstn(rstn),
    .invalid_guest_state_exit(invalid_guest_state_exit),
    .nested_page_fault_exit(nested_page_fault_exit),
    .virtual_ipi_incomplete_exit(virtual_ipi_incomplete_exit),
    .unaccelerated_vapic_exit(unaccelerated_vapic_exit),
    .port_io_exit(port_io_exit),
    .model_reg_access_exit(model_reg_access_exit),
    .fp_error_freeze_exit(fp_error_freeze_exit),
    .shutdown_exit(shutdown_exit),
    .monitor_wait_exit(monitor_wait_exit),
    .intercept_exit(intercept_exit),
    .monitor_armed(monitor_armed),
    .fp_legacy_enable(fp_legacy_enable),
    .intercept_bit(intercept_bit),
    .detail_one_in(detail_one_in),
    .detail_two_in(detail_two_in),
    .exit_valid(exit_valid),
    .exit_reject(exit_reject),
    .exit_code(exit_code),
    .exit_detail_one(exit_detail_one),
    .exit_detail_two(exit_detail_two)
);

/* File: test/gxr_encoder_bench.sv */
// Random and corner-case bench for the exit encoder.
`timescale 1ns/1ps
`include "gxr_consts.vh"
module gxr_encoder_bench;
    reg clk = 1'h0;
    reg rstn = 1'h0;
    reg [9:0] c = 10'h0;
    reg [31:0] r = 32'h0;
    reg [63:0] d1 = 64'h0, d2 = 64'h0, ec = 64'h0, e1, e2, hc = 64'h0;
    reg ev = 1'h0, er = 1'h0;
    wire ok, rj;
    wire [63:0] code, o1, o2, seen;
    integer seed = 11543, err_total = 0, compares = 0, i, w;
    gxr_encoder #(.IVW(8)) dut (.clk(clk), .rstn(rstn),
        .invalid_guest_state_exit(c[0]), .nested_page_fault_exit(c[1]),
        .virtual_ipi_incomplete_exit(c[2]), .unaccelerated_vapic_exit(c[3]),
        .port_io_exit(c[4]), .model_reg_access_exit(c[5]),
        .fp_error_freeze_exit(c[6]), .shutdown_exit(c[7]),
        .monitor_wait_exit(c[8]), .intercept_exit(c[9]),
        .monitor_armed(r[0]), .fp_legacy_enable(r[1]),
        .intercept_bit(r[9:2]), .detail_one_in(d1), .detail_two_in(d2),
        .exit_valid(ok), .exit_code(code), .exit_detail_one(o1),
        .exit_detail_two(o2), .exit_reject(rj));
    gxr_host host (.clk(clk), .exit_valid(ok), .exit_code(code),
        .seen_code(seen));
    initial forever #25 clk = ~clk;
    task check(input reg bad);
        begin
            compares = compares + 1;
            if (bad)
            begin
                $display("ERROR %0t mismatch at step %0d", $time, i);
                err_total = err_total + 1;
            end
        end
    endtask
    task conclude;
        begin
            $display("compares %0d err_total %0d", compares, err_total);
            if (err_total == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    // Lowest set cause wins; a freeze without legacy handling is no cause.
    function integer win(input [9:0] v, input f);
        integer k;
        begin
            win = 10;
            for (k = 9; k >= 0; k = k - 1)
                if (v[k] && (k != 6 || f))
                    win = k;
        end
    endfunction
    function [63:0] code_of(input integer k, input a, input [7:0] b);
        case (k)
            0: code_of = `GXR_CODE_INVALID;
            1: code_of = `GXR_CODE_NPF;
            2: code_of = `GXR_CODE_VIPI;
            3: code_of = `GXR_CODE_NOACCEL;
            4: code_of = `GXR_CODE_PORT_IO;
            5: code_of = `GXR_CODE_MODEL_REG;
            6: code_of = `GXR_CODE_FP_FREEZE;
            7: code_of = `GXR_CODE_SHUTDOWN;
            8: code_of = a ? `GXR_CODE_MONITOR_WAIT_INSTR_ARMED : `GXR_CODE_MONITOR_WAIT_INSTR;
            default: code_of = {56'h0, b};
        endcase
    endfunction
    initial
    begin
        repeat (2) @(negedge clk);
        rstn = 1'h1;
        for (i = 0; i < 700; i = i + 1)
        begin
            @(negedge clk);
            check(ok !== ev || rj !== er);
            check(code !== ec);
            check(seen !== hc);
            if (ev)
            begin
                check(o1 !== e1);
                check(o2 !== e2);
                hc = ec;
            end
            r = $random(seed);
            c = r[19:10] & r[29:20];
            if (i < 3)
                c = 10'h200;
            if (i < 3)
                r[9:2] = 8'h8c + i[7:0];
            if (i == 3)
                c = 10'h003;
            d1 = {$random(seed), $random(seed)};
            d2 = {$random(seed), $random(seed)};
            w = win(c, r[1]);
            er = (w == 9 && r[9:2] > 8'h8d);
            ev = (w < 10 && !er);
            if (ev)
                ec = code_of(w, r[0], r[9:2]);
            e1 = (w >= 1 && w <= 4) ? d1 : 64'h0;
            e2 = (w >= 1 && w <= 3) ? d2 : 64'h0;
        end
        $display("random exit run done");
        conclude;
    end
endmodule
